// file: design/mo_muting_override.sv
// Overview of operation
// - Enable/disable mode: enable rise arms a cycle, enable fall ends muting.
// - Enable-only mode: enable never ends muting; must drop before rearming.
// - Direction: both ways, first-to-fourth only, or fourth-to-first only.
// - Curtain closing: muting ends when curtain rises after material passed.
// - Sensor closing: muting ends when third sensor in order is released.
// - Curtain closing may add a blind time where curtain reads as 1.
// - T muting starts when both sensors occupy within the sensors time.
// - T muting ends as soon as either sensor is released.
// - T muting may begin only with both sensors 0 and curtain 1.
// - Muting ends at once when the cycle timeout expires.
// - Without the enable option muting is always enabled.
// - Override taken only while muting output 0 and something occupied.
// - Override ends, output 0, when curtain and all sensors clear.
// - Key mode: command held throughout; release and reassert for new one.
// - Pushbutton: command assertion starts override until clear or timeout.
// - Override ends when its configurable timeout expires.
// - Override-active output high while override in progress, if enabled.
// - Request output high while override start conditions hold, if enabled.
// - With reset: muting 1 needs reset to enable; else follows override.
// - Manual reset on 0-to-1; monitored needs 0-to-1 then back to 0.
`timescale 1ns/10ps
module mo_muting_override #(
    parameter int MS_CYC = mo_pkg::MS_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire mo_pkg::mo_pins_t pins,
    output logic                  muting_out,
    output logic                  block_out,
    output logic                  override_active_out,
    output logic                  request_out
);
    import mo_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // A limit of zero never expires
    function automatic logic expired(input logic [15:0] cnt,
                                     input logic [15:0] lim);
        expired = (lim != 16'h0000) && (cnt >= lim);
    endfunction

    function automatic logic [15:0] bump(input logic [15:0] cnt,
                                         input logic        tick);
        bump = (tick && cnt != 16'hffff) ? cnt + 16'h0001 : cnt;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    mo_pins_t pin_m;
    mo_pins_t pin_s;
    mo_pins_t pin_p;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_m <= '0;
            pin_s <= '0;
            pin_p <= '0;
        end else begin
            pin_m <= pins;
            pin_s <= pin_m;
            pin_p <= pin_s;
        end
    end

    wire logic [3:0] s       = pin_s.sensor;
    wire logic       curtain = pin_s.curtain;
    wire logic en_rise  = pin_s.enable & ~pin_p.enable;
    wire logic en_fall  = ~pin_s.enable & pin_p.enable;
    wire logic cmd_rise = pin_s.ovr_cmd & ~pin_p.ovr_cmd;
    wire logic rs_rise  = pin_s.reset_in & ~pin_p.reset_in;
    wire logic rs_fall  = ~pin_s.reset_in & pin_p.reset_in;

    // ****************************************
    // Registers and APB slave
    // ****************************************
    logic [11:0] ctrl;
    logic [15:0] tmo_ms;
    logic [15:0] stime_ms;
    logic [15:0] blind_ms;
    logic [15:0] otmo_ms;
    mo_state_t   state;
    logic        ovr_act;

    wire mo_cfg_t cfg = mo_cfg_t'(ctrl);
    wire logic sel_ctrl  = (paddr == OFF_CTRL);
    wire logic sel_tmo   = (paddr == OFF_TIMEOUT);
    wire logic sel_stime = (paddr == OFF_SENS_TIME);
    wire logic sel_blind = (paddr == OFF_BLIND);
    wire logic sel_otmo  = (paddr == OFF_OVR_TMO);
    wire logic sel_stat  = (paddr == OFF_STATUS);
    wire logic mapped    = sel_ctrl | sel_tmo | sel_stime | sel_blind
                         | sel_otmo | sel_stat;
    // One wait state so read data leaves a flip-flop
    wire logic acc   = psel & penable & ~pready;
    wire logic wr_ok = psel & penable & pready & pwrite & ~pslverr;
    wire logic [31:0] status = {22'h0, ovr_act, state, request_out,
                                override_active_out, block_out,
                                muting_out, 2'h0};
    wire logic [31:0] rd_mux =
        sel_ctrl  ? {20'h0, ctrl}     :
        sel_tmo   ? {16'h0, tmo_ms}   :
        sel_stime ? {16'h0, stime_ms} :
        sel_blind ? {16'h0, blind_ms} :
        sel_otmo  ? {16'h0, otmo_ms}  :
        sel_stat  ? status            : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= acc;
            pslverr <= acc & (~mapped | (pwrite & sel_stat));
            prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl     <= RST_CTRL;
            tmo_ms   <= RST_TIMEOUT;
            stime_ms <= RST_SENS_TIME;
            blind_ms <= RST_BLIND;
            otmo_ms  <= RST_OVR_TMO;
        end else if (wr_ok) begin
            if (sel_ctrl)  ctrl     <= pwdata[11:0];
            if (sel_tmo)   tmo_ms   <= pwdata[15:0];
            if (sel_stime) stime_ms <= pwdata[15:0];
            if (sel_blind) blind_ms <= pwdata[15:0];
            if (sel_otmo)  otmo_ms  <= pwdata[15:0];
        end
    end

    // ****************************************
    // Millisecond tick
    // ****************************************
    // Counters restart on a free tick, so a window may run up to 1 ms short
    logic [31:0] pre;
    wire logic   tick = (pre == 32'(MS_CYC - 1));

    always_ff @(posedge clk) begin
        if (rst) pre <= 32'h0;
        else     pre <= tick ? 32'h0 : pre + 32'h1;
    end

    // ****************************************
    // Muting sequencer
    // ****************************************
    logic        en_ok;
    logic        dir_down;
    logic        seen_low;
    logic        third_seen;
    logic [15:0] cyc_cnt;
    logic [15:0] ph_cnt;
    mo_state_t   next_state;
    logic        next_dir_down;

    wire logic en_go = ~cfg.with_enable | en_ok;
    wire logic en_kill = cfg.with_enable & ~cfg.enable_only & en_fall;
    wire logic used_clr = cfg.t_mode ? ~|s[1:0] : ~|s;
    wire logic prelim = used_clr & curtain;
    wire logic pair_a = dir_down ? s[3] : s[0];
    wire logic pair_b = dir_down ? s[2] : s[1];
    wire logic third  = dir_down ? s[1] : s[2];
    wire logic up_ok = (cfg.direction != down_direction) & s[0];
    wire logic dn_ok = (cfg.direction != up_direction) & s[3];
    wire logic cyc_tmo = expired(cyc_cnt, tmo_ms);
    wire logic st_tmo  = expired(ph_cnt, stime_ms);
    wire logic bl_done = expired(ph_cnt, blind_ms) | (blind_ms == 16'h0);
    wire logic in_cycle = (state == ST_FIRST) | (state == ST_MUTE);
    wire logic start = (state == ST_READY) & en_go
                     & (next_state == ST_FIRST);

    always_comb begin
        next_state    = state;
        next_dir_down = dir_down;
        unique case (state)
            ST_IDLE: begin
                if (prelim) next_state = ST_READY;
            end
            ST_READY: begin
                if (!prelim && !cfg.t_mode && en_go && up_ok) begin
                    next_state    = ST_FIRST;
                    next_dir_down = 1'b0;
                end else if (!prelim && !cfg.t_mode && en_go && dn_ok) begin
                    next_state    = ST_FIRST;
                    next_dir_down = 1'b1;
                end else if (cfg.t_mode && en_go && |s[1:0] && curtain) begin
                    next_state    = ST_FIRST;
                end else if (!prelim) begin
                    next_state = ST_WAIT;
                end
            end
            ST_FIRST: begin
                if (en_kill || cyc_tmo) begin
                    next_state = ST_WAIT;
                end else if (cfg.t_mode) begin
                    if (&s[1:0])     next_state = ST_MUTE;
                    else if (st_tmo) next_state = ST_WAIT;
                end else if (pair_a && pair_b) begin
                    next_state = ST_MUTE;
                end
            end
            ST_MUTE: begin
                if (en_kill || cyc_tmo) begin
                    next_state = ST_WAIT;
                end else if (cfg.t_mode) begin
                    if (!(&s[1:0])) next_state = ST_WAIT;
                end else if (cfg.sensor_close) begin
                    if (third_seen && !third) next_state = ST_WAIT;
                end else if (!pair_a && !pair_b && seen_low && curtain) begin
                    next_state = cfg.blind_en ? ST_BLIND : ST_WAIT;
                end
            end
            ST_BLIND: begin
                if (en_kill || bl_done) next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (used_clr) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= ST_IDLE;
            dir_down <= 1'b0;
        end else begin
            state    <= next_state;
            dir_down <= next_dir_down;
        end
    end

    // Each cycle consumes one enable rise; set wins over clear
    always_ff @(posedge clk) begin
        if (rst)                 en_ok <= 1'b0;
        else if (en_rise)        en_ok <= 1'b1;
        else if (en_kill | start) en_ok <= 1'b0;
    end

    // Phase counter restarts on each phase; cycle counter runs on through FIRST and MUTE
    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_cnt    <= 16'h0;
            ph_cnt     <= 16'h0;
            seen_low   <= 1'b0;
            third_seen <= 1'b0;
        end else begin
            cyc_cnt    <= in_cycle ? bump(cyc_cnt, tick) : 16'h0;
            ph_cnt     <= (next_state == state) ? bump(ph_cnt, tick)
                                                : 16'h0;
            seen_low   <= (state == ST_MUTE) & (seen_low | ~curtain);
            third_seen <= (state == ST_MUTE) & (third_seen | third);
        end
    end

    wire logic next_muting = curtain | (state == ST_MUTE)
                           | (state == ST_BLIND);

    // ****************************************
    // Override
    // ****************************************
    logic        rs_pend;
    logic        rs_ok;
    logic [15:0] ov_cnt;

    wire logic gap_free = ~|s & curtain;
    wire logic ovr_cond = ~muting_out & (|s | ~curtain);
    wire logic ov_tmo   = expired(ov_cnt, otmo_ms);
    wire logic key_lost = ~cfg.pushbutton & ~pin_s.ovr_cmd;
    wire logic ovr_end  = gap_free | ov_tmo | key_lost;
    wire logic next_ovr = ovr_act ? ~ovr_end : (ovr_cond & cmd_rise);
    wire logic rs_acc   = cfg.reset_monitored ? (rs_fall & rs_pend)
                                              : rs_rise;

    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_act <= 1'b0;
            ov_cnt  <= 16'h0;
            rs_pend <= 1'b0;
            rs_ok   <= 1'b0;
        end else begin
            ovr_act <= next_ovr;
            ov_cnt  <= ovr_act ? bump(ov_cnt, tick) : 16'h0;
            rs_pend <= rs_rise | (rs_pend & ~rs_fall);
            rs_ok   <= muting_out & (rs_ok | rs_acc);
        end
    end

    wire logic next_block = next_ovr
                          | (muting_out & (~cfg.reset_en | rs_ok));

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            muting_out          <= 1'b0;
            block_out           <= 1'b0;
            override_active_out <= 1'b0;
            request_out         <= 1'b0;
        end else begin
            muting_out          <= next_muting;
            block_out           <= next_block;
            override_active_out <= cfg.with_override_active_out & next_ovr;
            request_out         <= cfg.with_request & ovr_cond;
        end
    end

endmodule

// file: pkg/mo_pkg.sv
package mo_pkg;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_TIMEOUT    = 8'h04;
    localparam logic [7:0]  OFF_SENS_TIME  = 8'h08;
    localparam logic [7:0]  OFF_BLIND      = 8'h0c;
    localparam logic [7:0]  OFF_OVR_TMO    = 8'h10;
    localparam logic [7:0]  OFF_STATUS     = 8'h14;
    localparam logic [11:0] RST_CTRL       = 12'h000;
    localparam logic [15:0] RST_TIMEOUT    = 16'h2710;
    localparam logic [15:0] RST_SENS_TIME  = 16'h07d0;
    localparam logic [15:0] RST_BLIND      = 16'h00fa;
    localparam logic [15:0] RST_OVR_TMO    = 16'h2710;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        both_ways_direction = 2'h0,
        up_direction        = 2'h1,
        down_direction      = 2'h2
    } mo_dir_t;

    // Layout of the control register, bit 11 down to bit 0
    typedef struct packed {
        logic    t_mode;
        logic    with_enable;
        logic    enable_only;
        mo_dir_t direction;
        logic    sensor_close;
        logic    blind_en;
        logic    reset_en;
        logic    reset_monitored;
        logic    pushbutton;
        logic    with_override_active_out;
        logic    with_request;
    } mo_cfg_t;

    typedef struct packed {
        logic [3:0] sensor;
        logic       curtain;
        logic       enable;
        logic       ovr_cmd;
        logic       reset_in;
    } mo_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_READY = 3'h1,
        ST_FIRST = 3'h3,
        ST_MUTE  = 3'h2,
        ST_BLIND = 3'h6,
        ST_WAIT  = 3'h7
    } mo_state_t;

endpackage

// file: bench/mo_muting_override_chk.sv
`timescale 1ns/10ps
module mo_chk #(
    parameter int MS_CYC = 10
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire mo_pkg::mo_pins_t pins,
    input wire logic             muting_out,
    input wire logic             block_out,
    input wire logic             override_active_out,
    input wire logic             request_out
);
    import mo_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Refused accesses: unmapped, unaligned, or a write to the status word
    wire logic err_case = (paddr > OFF_STATUS) || (paddr[1:0] != 2'h0)
                        || (pwrite && (paddr == OFF_STATUS));
    wire logic all_clear = pins.curtain && (pins.sensor == 4'h0);

    // ****************************************
    // Properties
    // ****************************************
    property p_ready_after; psel && $rose(penable) |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_only; pslverr |-> pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_err_decode;
        psel && $rose(penable) && err_case |=> pslverr;
    endproperty
    // Curtain free always passes; three cycles of pin lag, and the pin
    // flops are still cleared by reset at the first sampled edge
    property p_curtain_pass;
        pins.curtain [*4] ##0 !$past(rst, 3) |-> muting_out;
    endproperty
    property p_clear_ovr; all_clear [*8] |-> !override_active_out; endproperty
    property p_clear_req; all_clear [*8] |-> !request_out; endproperty

    a_ready_after: assert property (p_ready_after)
        else $error("pready missing after access phase");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_err_only: assert property (p_err_only)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("prdata nonzero outside answer");
    a_err_decode: assert property (p_err_decode)
        else $error("refused access not flagged");
    a_curtain_pass: assert property (p_curtain_pass)
        else $error("free curtain not passed through");
    a_clear_ovr: assert property (p_clear_ovr)
        else $error("override kept with gap clear");
    a_clear_req: assert property (p_clear_req)
        else $error("request shown with gap clear");

    c_mute: cover property ($rose(muting_out));
    c_ovr: cover property ($rose(override_active_out));
    c_req: cover property ($rose(request_out));
    c_err: cover property (pslverr);
endmodule

bind mo_muting_override mo_chk #(.MS_CYC(MS_CYC)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .muting_out(muting_out),
    .block_out(block_out), .override_active_out(override_active_out),
    .request_out(request_out));

// file: bench/mo_muting_override_bench.sv
`timescale 1ns/10ps
module mo_muting_override_bench;
    import mo_pkg::*;
    localparam int MSC = 10;
    // Passage rows {s1,s2,curtain,s3,s4,out curtain close,out sensor close}
    localparam logic [6:0] ROWS [12] = '{7'h13, 7'h53, 7'h73, 7'h63, 7'h6b,
        7'h6f, 7'h2f, 7'h0f, 7'h1f, 7'h0d, 7'h04, 7'h13};
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, en_v;
    logic        muting_out, block_out, override_active_out, request_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd, q;
    mo_pins_t    pn;
    mo_cfg_t     cfg;
    int          failures, checks_done;
    bit          ok;

    mo_muting_override #(.MS_CYC(MSC)) dut_u (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pn), .muting_out(muting_out), .block_out(block_out),
        .override_active_out(override_active_out), .request_out(request_out));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************
    // Expectations
    // ****************************************
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Mirrored rows give the fourth-to-first passage
    function automatic logic [3:0] sens(logic [6:0] r, bit rev);
        return rev ? {r[6], r[5], r[3], r[2]} : {r[2], r[3], r[5], r[6]};
    endfunction
    // A refused order never mutes, so only the curtain shows
    function automatic logic exp_mute(logic [6:0] r, bit ok, bit cls);
        return !ok ? r[4] : (cls ? r[0] : r[1]);
    endfunction

    // ****************************************
    // Tasks
    // ****************************************
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] ex, logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, ex, got);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] ex, logic er);
        apb(1'b0, a, 32'h0);
        chk("prdata", ex, q);
        chk("pslverr", {31'h0, er}, {31'h0, e});
    endtask
    task automatic setcfg();
        apb(1'b1, OFF_CTRL, {20'h0, cfg});
    endtask
    task automatic step(logic [3:0] s, logic c, logic o, logic r);
        @(posedge clk);
        pn <= {s, c, en_v, o, r};
        repeat (6) @(posedge clk);
    endtask
    task automatic idle();
        step(4'h0, 1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
    endtask
    task automatic pass(int n, bit rev, bit ok, bit cls, bit cmp);
        for (int i = 0; i < n; i++) begin
            step(sens(ROWS[i], rev), ROWS[i][4], 1'b0, 1'b0);
            if (cmp) chk("muting_out", {31'h0, exp_mute(ROWS[i], ok, cls)},
                {31'h0, muting_out});
        end
    endtask
    task automatic mute_is(logic ex);
        chk("muting_out", {31'h0, ex}, {31'h0, muting_out});
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        stop_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, en_v} = '0;
        pn = 8'h08;
        failures = 0;
        checks_done = 0;
        rnd = 32'h12bab693;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CTRL, {20'h0, RST_CTRL}, 1'b0);
        rd(OFF_TIMEOUT, {16'h0, RST_TIMEOUT}, 1'b0);
        rd(OFF_SENS_TIME, {16'h0, RST_SENS_TIME}, 1'b0);
        rd(OFF_BLIND, {16'h0, RST_BLIND}, 1'b0);
        rd(OFF_OVR_TMO, {16'h0, RST_OVR_TMO}, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        apb(1'b1, OFF_STATUS, 32'hffffffff);
        chk("pslverr", 32'h1, {31'h0, e});
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            apb(1'b1, OFF_TIMEOUT + 8'(4 * (i % 4)), rnd);
            rd(OFF_TIMEOUT + 8'(4 * (i % 4)), {16'h0, rnd[15:0]}, 1'b0);
        end
        $display("registers done");
        apb(1'b1, OFF_TIMEOUT, 32'h0);
        apb(1'b1, OFF_SENS_TIME, 32'h2);
        apb(1'b1, OFF_BLIND, 32'h3);
        apb(1'b1, OFF_OVR_TMO, 32'h0);
        for (int m = 0; m < 12; m++) begin
            cfg = '0;
            cfg.direction = mo_dir_t'(m % 3);
            cfg.sensor_close = m / 6;
            ok = (m % 3 == 0) || (m % 3 == 1) != ((m / 3) % 2 == 1);
            setcfg();
            idle();
            pass(12, (m / 3) % 2, ok, m / 6, 1'b1);
        end
        $display("passage done");
        cfg = '0;
        cfg.blind_en = 1'b1;
        setcfg();
        idle();
        pass(9, 1'b0, 1'b1, 1'b0, 1'b0);
        step(4'hc, 1'b0, 1'b0, 1'b0);
        mute_is(1'b1);
        repeat (40) @(posedge clk);
        mute_is(1'b0);
        idle();
        apb(1'b1, OFF_TIMEOUT, 32'h8);
        cfg = '0;
        setcfg();
        idle();
        pass(4, 1'b0, 1'b1, 1'b0, 1'b1);
        repeat (80) @(posedge clk);
        mute_is(1'b0);
        apb(1'b1, OFF_TIMEOUT, 32'h0);
        idle();
        $display("blind and timeout done");
        cfg.t_mode = 1'b1;
        setcfg();
        idle();
        step(4'h3, 1'b1, 1'b0, 1'b0);
        step(4'h3, 1'b0, 1'b0, 1'b0);
        mute_is(1'b1);
        step(4'h1, 1'b0, 1'b0, 1'b0);
        mute_is(1'b0);
        idle();
        step(4'h1, 1'b1, 1'b0, 1'b0);
        repeat (40) @(posedge clk);
        step(4'h3, 1'b0, 1'b0, 1'b0);
        mute_is(1'b0);
        idle();
        step(4'h0, 1'b0, 1'b0, 1'b0);
        step(4'h3, 1'b0, 1'b0, 1'b0);
        mute_is(1'b0);
        idle();
        $display("t mode done");
        for (int k = 0; k < 2; k++) begin
            cfg = '0;
            cfg.with_enable = 1'b1;
            cfg.enable_only = k;
            setcfg();
            idle();
            pass(4, 1'b0, 1'b1, 1'b0, 1'b0);
            mute_is(1'b0);
            en_v = 1'b1;
            idle();
            pass(4, 1'b0, 1'b1, 1'b0, 1'b0);
            mute_is(1'b1);
            en_v = 1'b0;
            step(4'h3, 1'b0, 1'b0, 1'b0);
            mute_is(k[0]);
            idle();
        end
        $display("enable done");
        cfg = '0;
        {cfg.pushbutton, cfg.with_override_active_out, cfg.with_request} = 3'h7;
        setcfg();
        idle();
        step(4'h1, 1'b0, 1'b0, 1'b0);
        chk("request_out", 32'h1, {31'h0, request_out});
        step(4'h1, 1'b0, 1'b1, 1'b0);
        chk("override", 32'h1, {31'h0, override_active_out});
        chk("block_out", 32'h1, {31'h0, block_out});
        step(4'h1, 1'b0, 1'b0, 1'b0);
        chk("override", 32'h1, {31'h0, override_active_out});
        idle();
        chk("override", 32'h0, {31'h0, override_active_out});
        apb(1'b1, OFF_OVR_TMO, 32'h3);
        cfg.pushbutton = 1'b0;
        setcfg();
        step(4'h2, 1'b0, 1'b0, 1'b0);
        step(4'h2, 1'b0, 1'b1, 1'b0);
        chk("override", 32'h1, {31'h0, override_active_out});
        repeat (50) @(posedge clk);
        chk("override", 32'h0, {31'h0, override_active_out});
        step(4'h2, 1'b0, 1'b1, 1'b0);
        chk("override", 32'h0, {31'h0, override_active_out});
        step(4'h2, 1'b0, 1'b0, 1'b0);
        step(4'h2, 1'b0, 1'b1, 1'b0);
        chk("override", 32'h1, {31'h0, override_active_out});
        step(4'h2, 1'b0, 1'b0, 1'b0);
        chk("override", 32'h0, {31'h0, override_active_out});
        idle();
        $display("override done");
        for (int k = 0; k < 2; k++) begin
            cfg = '0;
            cfg.reset_en = 1'b1;
            cfg.reset_monitored = k;
            setcfg();
            // Blocked curtain without muting drops any accepted reset
            step(4'h0, 1'b0, 1'b0, 1'b0);
            idle();
            pass(4, 1'b0, 1'b1, 1'b0, 1'b0);
            chk("block_out", 32'h0, {31'h0, block_out});
            step(4'h3, 1'b0, 1'b0, 1'b1);
            chk("block_out", {31'h0, ~k[0]}, {31'h0, block_out});
            step(4'h3, 1'b0, 1'b0, 1'b0);
            chk("block_out", 32'h1, {31'h0, block_out});
            idle();
        end
        $display("reset done");
        stop_test();
    end
endmodule
